/* File: pkg/dsad_pkg.sv */
// Constants and types of the data-space address decoder
package dsad_pkg;
  // ------------------------------------------------------------
  // Data space geometry
  // ------------------------------------------------------------
  localparam int EA_W = 16;
  localparam int PAGE_W = 8;
  localparam int PADDR_W = 24;
  localparam int PWORD_W = 24;
  localparam int WIN_LOW_W = 15;
  localparam int PAGE_WORDS = 16384;
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h07FF;
  localparam logic [15:0] XRAM_LO = 16'h0800;
  localparam logic [15:0] XRAM_HI = 16'h08FF;
  localparam logic [15:0] YRAM_LO = 16'h0900;
  localparam logic [15:0] YRAM_HI = 16'h09FF;
  localparam int WIN_BIT = 15;
  localparam int RAM_AW = 8;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] ZERO_W = 16'h0000;
  localparam logic [1:0] LANES_ALL = 2'h3;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANES_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;
  localparam logic [1:0] EXTRA_NONE = 2'h0;

  // ------------------------------------------------------------
  // APB register map
  // ------------------------------------------------------------
  localparam logic [7:0] CORE_CTRL_OFS = 8'h00;
  localparam logic [7:0] WIN_PAGE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] XMOD_START_OFS = 8'h0C;
  localparam logic [7:0] XMOD_END_OFS = 8'h10;
  localparam logic [7:0] YMOD_START_OFS = 8'h14;
  localparam logic [7:0] YMOD_END_OFS = 8'h18;
  localparam logic [7:0] BREV_OFS = 8'h1C;
  localparam int CTRL_WIN_EN_BIT = 0;
  localparam int CTRL_XMOD_BIT = 1;
  localparam int CTRL_YMOD_BIT = 2;
  localparam int BREV_EN_BIT = 15;
  localparam int ST_ADDR_ERR_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DSAD_RG_SFR = 3'b000,
    DSAD_RG_XRAM = 3'b001,
    DSAD_RG_YRAM = 3'b010,
    DSAD_RG_PROG = 3'b011,
    DSAD_RG_NONE = 3'b100
  } dsad_region_e;

  typedef enum logic [1:0] {
    DSAD_OP_MAC_PF = 2'b00,
    DSAD_OP_MOV = 2'b01,
    DSAD_OP_MOVD = 2'b10,
    DSAD_OP_OTHER = 2'b11
  } dsad_op_e;
endpackage : dsad_pkg

/* File: rtl/dsad_agu.sv */
// Pointer post-modify unit: size scaling, modulo wrap, bit-reversed step
`timescale 1ns/1ps
module dsad_agu
  import dsad_pkg::*;
(
  // Pointer and operation
  input wire logic [15:0] ptr_i,
  input wire logic byte_i,
  input wire logic dec_i,
  // Modulo window
  input wire logic mod_en_i,
  input wire logic [15:0] mod_start_i,
  input wire logic [15:0] mod_end_i,
  // Bit-reversed stepping
  input wire logic brev_en_i,
  input wire logic [15:0] brev_mod_i,
  // Result
  output logic [15:0] next_o
);
  import dsad_pkg::*;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = ZERO_W;
    for (int i = 0; i < EA_W; i++)
    begin
      r[i] = v[EA_W-1-i];
    end
    return r;
  endfunction : rev16

  logic [15:0] step;
  logic [15:0] lin;

  always_comb
  begin
    step = byte_i ? STEP_BYTE : STEP_WORD;
    lin = dec_i ? ptr_i - step : ptr_i + step;
    next_o = lin;
    if (brev_en_i)
    begin
      next_o = rev16(rev16(ptr_i) + rev16(brev_mod_i));
    end
    else if (mod_en_i)
    begin
      if (!dec_i && ptr_i >= mod_end_i - step + STEP_BYTE)
      begin
        next_o = mod_start_i;
      end
      else if (dec_i && ptr_i <= mod_start_i)
      begin
        next_o = mod_end_i - step + STEP_BYTE;
      end
    end
  end
endmodule : dsad_agu

/* File: rtl/dsad_decoder.sv */
// Data-space address decoder: X/Y split, program window, lanes, traps
`timescale 1ns/1ps
module dsad_decoder
  import dsad_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core access request
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic acc_byte_i,
  input wire logic [dsad_pkg::EA_W-1:0] acc_ea_i,
  input wire logic [15:0] acc_wdata_i,
  input wire logic acc_wreg_dst_i,
  input wire logic mac_i,
  input wire logic y_req_i,
  input wire logic [dsad_pkg::EA_W-1:0] y_ea_i,
  input wire logic table_op_i,
  input wire dsad_pkg::dsad_op_e op_class_i,
  // Repeat loop status
  input wire logic rep_active_i,
  input wire logic rep_first_i,
  input wire logic rep_last_i,
  input wire logic rep_int_exit_i,
  input wire logic rep_reentry_i,
  // Pointer post-modify
  input wire logic post_dec_i,
  input wire logic brev_i,
  // Core answers
  output logic acc_ready_o,
  output logic rdata_valid_o,
  output logic [15:0] x_rdata_o,
  output logic [15:0] y_rdata_o,
  output logic [1:0] wreg_lanes_o,
  output logic addr_err_o,
  output logic [15:0] x_ptr_next_o,
  output logic [15:0] y_ptr_next_o,
  // SFR port
  output logic [10:0] sfr_addr_o,
  output logic sfr_rd_o,
  output logic [1:0] sfr_we_o,
  output logic [15:0] sfr_wdata_o,
  input wire logic [15:0] sfr_rdata_i,
  // Data RAM X port
  output logic [dsad_pkg::RAM_AW-1:0] xram_addr_o,
  output logic xram_rd_o,
  output logic [1:0] xram_we_o,
  output logic [15:0] xram_wdata_o,
  input wire logic [15:0] xram_rdata_i,
  // Data RAM Y port, read only
  output logic [dsad_pkg::RAM_AW-1:0] yram_addr_o,
  output logic yram_rd_o,
  input wire logic [15:0] yram_rdata_i,
  // Program memory window port
  output logic [dsad_pkg::PADDR_W-1:0] prog_addr_o,
  output logic prog_rd_o,
  input wire logic [dsad_pkg::PWORD_W-1:0] prog_rdata_i
);
  import dsad_pkg::*;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // byte EA region map
  function automatic dsad_region_e region(input logic [15:0] ea, input logic win);
    if (ea[WIN_BIT])
    begin
      return win ? DSAD_RG_PROG : DSAD_RG_NONE;
    end
    else if (ea <= SFR_HI)
    begin
      return DSAD_RG_SFR;
    end
    else if (ea >= XRAM_LO && ea <= XRAM_HI)
    begin
      return DSAD_RG_XRAM;
    end
    else if (ea >= YRAM_LO && ea <= YRAM_HI)
    begin
      return DSAD_RG_YRAM;
    end
    return DSAD_RG_NONE;
  endfunction : region

  function automatic logic [RAM_AW-1:0] ram_word(input logic [15:0] ea);
    logic [15:0] off;
    off = ea - XRAM_LO;
    return off[RAM_AW:1];
  endfunction : ram_word

  // ------------------------------------------------------------
  // Registers reached over APB
  // ------------------------------------------------------------
  logic [2:0] core_control_reg_q;
  logic [PAGE_W-1:0] program_window_page_q;
  logic [15:0] xmod_start_q;
  logic [15:0] xmod_end_q;
  logic [15:0] ymod_start_q;
  logic [15:0] ymod_end_q;
  logic [15:0] brev_q;
  logic addr_err_st_q;
  logic [31:0] prdata_q;
  logic [1:0] wait_q;

  logic apb_setup;
  logic apb_wr;
  logic ofs_ok;
  logic [31:0] rd_mux;

  always_comb
  begin
    ofs_ok = 1'b1;
    rd_mux = '0;
    unique case (paddr_i)
      CORE_CTRL_OFS: rd_mux[2:0] = core_control_reg_q;
      WIN_PAGE_OFS: rd_mux[PAGE_W-1:0] = program_window_page_q;
      STATUS_OFS:
      begin
        rd_mux[ST_ADDR_ERR_BIT] = addr_err_st_q;
        rd_mux[ST_BUSY_BIT] = (wait_q != EXTRA_NONE);
      end
      XMOD_START_OFS: rd_mux[15:0] = xmod_start_q;
      XMOD_END_OFS: rd_mux[15:0] = xmod_end_q;
      YMOD_START_OFS: rd_mux[15:0] = ymod_start_q;
      YMOD_END_OFS: rd_mux[15:0] = ymod_end_q;
      BREV_OFS: rd_mux[15:0] = brev_q;
      default: ofs_ok = 1'b0;
    endcase
  end

  assign apb_setup = ce_i && psel_i && !penable_i;
  assign apb_wr = ce_i && psel_i && penable_i && pwrite_i && ofs_ok;
  // Zero-wait slave: read data is latched in the setup cycle
  assign pready_o = ce_i && psel_i && penable_i;
  assign pslverr_o = pready_o && !ofs_ok;
  assign prdata_o = prdata_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prdata_q <= '0;
    end
    else if (apb_setup)
    begin
      prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      core_control_reg_q <= CTRL_RST;
      program_window_page_q <= PAGE_RST;
      xmod_start_q <= ZERO_W;
      xmod_end_q <= ZERO_W;
      ymod_start_q <= ZERO_W;
      ymod_end_q <= ZERO_W;
      brev_q <= ZERO_W;
    end
    else if (apb_wr)
    begin
      // no register moves the X/Y boundary
      unique case (paddr_i)
        CORE_CTRL_OFS: core_control_reg_q <= pwdata_i[2:0];
        WIN_PAGE_OFS: program_window_page_q <= pwdata_i[PAGE_W-1:0];
        XMOD_START_OFS: xmod_start_q <= pwdata_i[15:0];
        XMOD_END_OFS: xmod_end_q <= pwdata_i[15:0];
        YMOD_START_OFS: ymod_start_q <= pwdata_i[15:0];
        YMOD_END_OFS: ymod_end_q <= pwdata_i[15:0];
        BREV_OFS: brev_q <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  logic accept;
  logic win_en;
  logic misalign;
  logic x_wrong;
  logic y_wrong;
  logic [1:0] lanes;
  logic [1:0] extra;
  dsad_region_e x_rg;
  dsad_region_e y_rg;

  assign acc_ready_o = (wait_q == EXTRA_NONE);
  assign accept = ce_i && acc_req_i && acc_ready_o;
  // window on MSB plus enable; suspended for table ops
  assign win_en = core_control_reg_q[CTRL_WIN_EN_BIT] && !table_op_i;
  // non-MAC X path covers the whole linear space
  assign x_rg = region(acc_ea_i, win_en);
  assign y_rg = region(y_ea_i, 1'b0);
  assign misalign = !acc_byte_i && acc_ea_i[0];
  // X pointers must stay out of Y, Y pointers inside Y
  assign x_wrong = mac_i && !acc_wr_i && (x_rg == DSAD_RG_YRAM);
  assign y_wrong = (y_rg != DSAD_RG_YRAM);

  always_comb
  begin
    // byte write strobes matching lane only
    if (acc_byte_i)
    begin
      lanes = acc_ea_i[0] ? LANE_HI : LANE_LO;
    end
    else
    begin
      lanes = LANES_ALL;
    end
    if (acc_wr_i && misalign)
    begin
      lanes = LANES_NONE;
    end
  end

  always_comb
  begin
    extra = EXTRA_NONE;
    if (x_rg == DSAD_RG_PROG)
    begin
      if (rep_active_i)
      begin
        // edge iterations pay two, others run single cycle
        if (rep_first_i || rep_last_i || rep_int_exit_i || rep_reentry_i)
        begin
          extra = EXTRA_TWO;
        end
      end
      // DSAD_OP_OTHER pays two extra cycles, MAC prefetch, MOV and MOV.D one
      else if (op_class_i == DSAD_OP_OTHER)
      begin
        extra = EXTRA_TWO;
      end
      else
      begin
        extra = EXTRA_ONE;
      end
    end
  end

  // ------------------------------------------------------------
  // Memory-side request registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sfr_addr_o <= '0;
      sfr_rd_o <= 1'b0;
      sfr_we_o <= LANES_NONE;
      sfr_wdata_o <= ZERO_W;
      xram_addr_o <= '0;
      xram_rd_o <= 1'b0;
      xram_we_o <= LANES_NONE;
      xram_wdata_o <= ZERO_W;
      prog_addr_o <= '0;
      prog_rd_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sfr_rd_o <= accept && !acc_wr_i && x_rg == DSAD_RG_SFR;
      // SFR and data RAM writes on the X bus, lane gated; window writes get no strobe
      sfr_we_o <= (accept && acc_wr_i && x_rg == DSAD_RG_SFR) ? lanes : LANES_NONE;
      xram_rd_o <= accept && !acc_wr_i && !x_wrong
        && (x_rg == DSAD_RG_XRAM || x_rg == DSAD_RG_YRAM);
      xram_we_o <= (accept && acc_wr_i && (x_rg == DSAD_RG_XRAM || x_rg == DSAD_RG_YRAM))
        ? lanes : LANES_NONE;
      // Program memory is read only through the window
      prog_rd_o <= accept && !acc_wr_i && x_rg == DSAD_RG_PROG;
      if (accept)
      begin
        sfr_addr_o <= acc_ea_i[10:0];
        xram_addr_o <= ram_word(acc_ea_i);
        sfr_wdata_o <= acc_wdata_i;
        xram_wdata_o <= acc_wdata_i;
        // page above low 15 EA bits, top bit clear
        prog_addr_o <= {1'b0, program_window_page_q, acc_ea_i[WIN_LOW_W-1:0]};
      end
    end
  end

  // Y path read concurrently, never written
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      yram_addr_o <= '0;
      yram_rd_o <= 1'b0;
    end
    else if (ce_i)
    begin
      yram_rd_o <= accept && mac_i && y_req_i && !y_wrong;
      if (accept)
      begin
        yram_addr_o <= ram_word(y_ea_i);
      end
    end
  end

  // ------------------------------------------------------------
  // Read return stage
  // ------------------------------------------------------------
  logic s1_q;
  logic s1_byte_q;
  logic s1_hi_q;
  logic s1_wreg_q;
  logic s1_y_q;
  dsad_region_e s1_rg_q;
  logic [15:0] word;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= 1'b0;
      s1_byte_q <= 1'b0;
      s1_hi_q <= 1'b0;
      s1_wreg_q <= 1'b0;
      s1_y_q <= 1'b0;
      s1_rg_q <= DSAD_RG_NONE;
    end
    else if (ce_i)
    begin
      s1_q <= accept && !acc_wr_i;
      if (accept)
      begin
        s1_byte_q <= acc_byte_i;
        s1_hi_q <= acc_ea_i[0];
        s1_wreg_q <= acc_wreg_dst_i;
        s1_y_q <= mac_i && y_req_i && !y_wrong;
        // wrong-space MAC reads fall to zero
        s1_rg_q <= x_wrong ? DSAD_RG_NONE : x_rg;
      end
    end
  end

  always_comb
  begin
    unique case (s1_rg_q)
      DSAD_RG_SFR: word = sfr_rdata_i;
      DSAD_RG_XRAM, DSAD_RG_YRAM: word = xram_rdata_i;
      DSAD_RG_PROG: word = prog_rdata_i[15:0];
      default: word = ZERO_W;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_valid_o <= 1'b0;
      x_rdata_o <= ZERO_W;
      y_rdata_o <= ZERO_W;
      wreg_lanes_o <= LANES_NONE;
    end
    else if (ce_i)
    begin
      rdata_valid_o <= s1_q;
      if (s1_q)
      begin
        // byte picked by EA bit 0 onto low lane
        x_rdata_o <= s1_byte_q ? {8'h00, s1_hi_q ? word[15:8] : word[7:0]} : word;
        // Y path words only, zero when out of Y
        y_rdata_o <= s1_y_q ? yram_rdata_i : ZERO_W;
        // byte load updates low register byte only
        wreg_lanes_o <= !s1_wreg_q ? LANES_NONE : (s1_byte_q ? LANE_LO : LANES_ALL);
      end
      else
      begin
        wreg_lanes_o <= LANES_NONE;
      end
    end
  end

  // ------------------------------------------------------------
  // Stall counter and address error
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wait_q <= EXTRA_NONE;
    end
    else if (ce_i)
    begin
      if (accept)
      begin
        wait_q <= extra;
      end
      else if (wait_q != EXTRA_NONE)
      begin
        wait_q <= wait_q - EXTRA_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr_err_o <= 1'b0;
      addr_err_st_q <= 1'b0;
    end
    else if (ce_i)
    begin
      // trap pulse one cycle after the access is accepted
      addr_err_o <= accept && misalign;
      // Set wins over a same-cycle write-one clear
      if (accept && misalign)
      begin
        addr_err_st_q <= 1'b1;
      end
      else if (apb_wr && paddr_i == STATUS_OFS && pwdata_i[ST_ADDR_ERR_BIT])
      begin
        addr_err_st_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pointer post-modify
  // ------------------------------------------------------------
  logic [15:0] x_next;
  logic [15:0] y_next;

  // X unit, bit-reverse gated to writes
  dsad_agu u_x_agu (
    .ptr_i(acc_ea_i),
    .byte_i(acc_byte_i),
    .dec_i(post_dec_i),
    .mod_en_i(core_control_reg_q[CTRL_XMOD_BIT]),
    .mod_start_i(xmod_start_q),
    .mod_end_i(xmod_end_q),
    .brev_en_i(brev_i && acc_wr_i && brev_q[BREV_EN_BIT]),
    .brev_mod_i({1'b0, brev_q[14:0]}),
    .next_o(x_next)
  );

  dsad_agu u_y_agu (
    .ptr_i(y_ea_i),
    .byte_i(1'b0),
    .dec_i(post_dec_i),
    .mod_en_i(core_control_reg_q[CTRL_YMOD_BIT]),
    .mod_start_i(ymod_start_q),
    .mod_end_i(ymod_end_q),
    .brev_en_i(1'b0),
    .brev_mod_i(ZERO_W),
    .next_o(y_next)
  );

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      x_ptr_next_o <= ZERO_W;
      y_ptr_next_o <= ZERO_W;
    end
    else if (accept)
    begin
      x_ptr_next_o <= x_next;
      y_ptr_next_o <= y_next;
    end
  end
endmodule : dsad_decoder

/* File: testbench/dsad_decoder_monitor.sv */
// Port-level assertions for the data-space decoder
`timescale 1ns/1ps
module dsad_decoder_monitor
  import dsad_pkg::*;
(
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic acc_byte_i,
  input wire logic [15:0] acc_ea_i,
  input wire logic mac_i,
  input wire logic y_req_i,
  input wire logic [15:0] y_ea_i,
  input wire logic table_op_i,
  input wire dsad_pkg::dsad_op_e op_class_i,
  input wire logic rep_active_i,
  input wire logic rep_first_i,
  input wire logic rep_last_i,
  input wire logic rep_int_exit_i,
  input wire logic rep_reentry_i,
  input wire logic acc_ready_o,
  input wire logic rdata_valid_o,
  input wire logic [15:0] x_rdata_o,
  input wire logic addr_err_o,
  input wire logic [1:0] xram_we_o,
  input wire logic [1:0] sfr_we_o,
  input wire logic xram_rd_o,
  input wire logic [15:0] xram_rdata_i,
  input wire logic [7:0] yram_addr_o,
  input wire logic yram_rd_o,
  input wire logic [23:0] prog_addr_o,
  input wire logic prog_rd_o,
  input wire logic [23:0] prog_rdata_i
);
  logic take;
  logic edge_rep;
  assign take = ce_i & acc_req_i & acc_ready_o;
  assign edge_rep = rep_first_i | rep_last_i | rep_int_exit_i | rep_reentry_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_win_gate: assert property (take && (!acc_ea_i[15] || table_op_i) |=> !prog_rd_o)
    else $error("Program read outside the window");
  a_win_addr: assert property (take && !acc_wr_i && acc_ea_i[15] |=> !prog_rd_o ||
    (prog_addr_o[14:0] == $past(acc_ea_i[14:0]) && !prog_addr_o[23]))
    else $error("Window address wrong");
  a_win_data: assert property (prog_rd_o && !$past(acc_byte_i) |=>
    rdata_valid_o && x_rdata_o == $past(prog_rdata_i[15:0])) else $error("Window data wrong");
  a_two_extra: assert property (prog_rd_o &&
    ($past(rep_active_i) ? $past(edge_rep) : $past(op_class_i) == DSAD_OP_OTHER)
    |-> !acc_ready_o ##1 !acc_ready_o ##1 acc_ready_o) else $error("Two extra cycles expected");
  a_one_extra: assert property (prog_rd_o && !$past(rep_active_i) &&
    $past(op_class_i) != DSAD_OP_OTHER |-> !acc_ready_o ##1 acc_ready_o)
    else $error("One extra cycle expected");
  a_rep_fast: assert property (prog_rd_o && $past(rep_active_i) && !$past(edge_rep)
    |-> acc_ready_o) else $error("Repeat iteration stalled");
  a_mac_yread: assert property (take && mac_i && y_req_i &&
    y_ea_i inside {[YRAM_LO:YRAM_HI]} |=> yram_rd_o && yram_addr_o[6:0] == $past(y_ea_i[7:1]))
    else $error("Y read missing");
  a_unimpl_zero: assert property (take && !acc_wr_i && !mac_i &&
    acc_ea_i inside {[16'h0A00:16'h7FFF]} |=> ##1 rdata_valid_o && x_rdata_o == 16'h0000)
    else $error("Unimplemented read not zero");
  a_byte_select: assert property (xram_rd_o && $past(acc_byte_i) |=> x_rdata_o ==
    {8'h00, ($past(acc_ea_i[0], 2) ? $past(xram_rdata_i[15:8]) : $past(xram_rdata_i[7:0]))})
    else $error("Byte select wrong");
  a_byte_lane: assert property (take && acc_wr_i && acc_byte_i &&
    acc_ea_i inside {[XRAM_LO:YRAM_HI]} |=> xram_we_o == ($past(acc_ea_i[0]) ? LANE_HI : LANE_LO))
    else $error("Byte lane wrong");
  a_odd_trap: assert property (take && !acc_byte_i && acc_ea_i[0] |=> addr_err_o &&
    xram_we_o == LANES_NONE && sfr_we_o == LANES_NONE) else $error("Odd word access not trapped");
endmodule : dsad_decoder_monitor

bind dsad_decoder dsad_decoder_monitor u_mon (.*);

/* File: testbench/dsad_mem_model.sv */
// Memories behind the decoder
`timescale 1ns/1ps
module dsad_mem_model
(
  // Clock
  input wire logic clk_i,
  // SFR port
  input wire logic [10:0] sfr_addr_i,
  input wire logic sfr_rd_i,
  output logic [15:0] sfr_rdata_o,
  // Data RAM, Y half shares the array
  input wire logic [7:0] xram_addr_i,
  input wire logic xram_rd_i,
  input wire logic [1:0] xram_we_i,
  input wire logic [15:0] xram_wdata_i,
  output logic [15:0] xram_rdata_o,
  input wire logic [7:0] yram_addr_i,
  input wire logic yram_rd_i,
  output logic [15:0] yram_rdata_o,
  // Program window
  input wire logic [23:0] prog_addr_i,
  input wire logic prog_rd_i,
  output logic [23:0] prog_rdata_o
);
  logic [15:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = {i[7:0] ^ 8'h5A, i[7:0]};
  always @(posedge clk_i)
  begin
    if (xram_we_i[0]) mem[xram_addr_i][7:0] <= xram_wdata_i[7:0];
    if (xram_we_i[1]) mem[xram_addr_i][15:8] <= xram_wdata_i[15:8];
  end
  // Unselected ports show inverted data, never a stale value
  assign xram_rdata_o = mem[xram_addr_i] ^ {16{!xram_rd_i}};
  assign yram_rdata_o = mem[{1'b1, yram_addr_i[6:0]}] ^ {16{!yram_rd_i}};
  assign sfr_rdata_o = {5'h15, sfr_addr_i[10:1], 1'b0} ^ {16{!sfr_rd_i}};
  assign prog_rdata_o = {prog_addr_i[7:0] ^ 8'hFF, prog_addr_i[15:0] ^ 16'h3C3C}
    ^ {24{!prog_rd_i}};
endmodule : dsad_mem_model

/* File: testbench/tb.sv */
// Self-checking bench for the data-space decoder
`timescale 1ns/1ps
module tb;
  import dsad_pkg::*;
  logic ref_clk_i = 0, rst_b_i = 0, ce_i = 1;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
  logic [7:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o;
  logic acc_req_i = 0, acc_wr_i = 0, acc_byte_i = 0, acc_wreg_dst_i = 0, mac_i = 0;
  logic y_req_i = 0, table_op_i = 0, post_dec_i = 0, brev_i = 0;
  logic rep_active_i = 0, rep_first_i = 0, rep_last_i = 0, rep_int_exit_i = 0, rep_reentry_i = 0;
  logic [15:0] acc_ea_i = 0, acc_wdata_i = 0, y_ea_i = 0;
  dsad_op_e op_class_i = DSAD_OP_MOV;
  logic acc_ready_o, rdata_valid_o, addr_err_o, sfr_rd_o, xram_rd_o, yram_rd_o, prog_rd_o;
  logic [15:0] x_rdata_o, y_rdata_o, x_ptr_next_o, y_ptr_next_o, sfr_wdata_o, xram_wdata_o;
  logic [15:0] sfr_rdata_i, xram_rdata_i, yram_rdata_i;
  logic [1:0] wreg_lanes_o, sfr_we_o, xram_we_o;
  logic [10:0] sfr_addr_o;
  logic [7:0] xram_addr_o, yram_addr_o;
  logic [23:0] prog_addr_o, prog_rdata_i;
  logic [15:0] sh [256];
  logic [15:0] ea, yea, wd, pn, x2, y2;
  logic [31:0] r, prd;
  logic [23:0] pa1;
  logic [7:0] pg;
  logic [3:0] rf;
  logic [1:0] we1, ln2;
  logic b, m, pd, wr, r1, r2, e1, pr1, v2, perr;
  int seed = 32'hCAF9;
  int n_fail = 0;
  int checks = 0;

  always #4 ref_clk_i = ~ref_clk_i;
  dsad_decoder dut (.*);
  dsad_mem_model u_mem (.clk_i(ref_clk_i), .sfr_addr_i(sfr_addr_o), .sfr_rd_i(sfr_rd_o),
    .sfr_rdata_o(sfr_rdata_i), .xram_addr_i(xram_addr_o), .xram_rd_i(xram_rd_o),
    .xram_we_i(xram_we_o), .xram_wdata_i(xram_wdata_o), .xram_rdata_o(xram_rdata_i),
    .yram_addr_i(yram_addr_o), .yram_rd_i(yram_rd_o), .yram_rdata_o(yram_rdata_i),
    .prog_addr_i(prog_addr_o), .prog_rd_i(prog_rd_o), .prog_rdata_o(prog_rdata_i));

  // ------------------------------------------------------------
  // Expectations and bus tasks
  // ------------------------------------------------------------
  function automatic logic [15:0] xexp(logic [15:0] a, logic bt, logic mc);
    logic [15:0] w;
    w = 16'h0000;
    if (a < XRAM_LO) w = {5'h15, a[10:1], 1'b0};
    else if (a <= YRAM_HI && !(mc && a >= YRAM_LO)) w = sh[a[8:1]];
    return bt ? {8'h00, (a[0] ? w[15:8] : w[7:0])} : w;
  endfunction : xexp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    {prd, perr} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
    @(posedge ref_clk_i);
  endtask : apb

  task automatic acc(input logic w, input logic bt, input logic [15:0] a, input logic [15:0] d);
    {acc_req_i, acc_wr_i, acc_byte_i, acc_ea_i, acc_wdata_i} <= {1'b1, w, bt, a, d};
    do @(posedge ref_clk_i); while (acc_ready_o !== 1'b1);
    acc_req_i <= 1'b0;
    #1;
    {r1, we1, e1, pr1, pa1, pn} = {acc_ready_o, xram_we_o, addr_err_o, prog_rd_o, prog_addr_o,
      x_ptr_next_o};
    @(posedge ref_clk_i);
    #1;
    {r2, v2, x2, y2, ln2} = {acc_ready_o, rdata_valid_o, x_rdata_o, y_rdata_o, wreg_lanes_o};
    @(posedge ref_clk_i);
  endtask : acc

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++) sh[i] = {i[7:0] ^ 8'h5A, i[7:0]};
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    apb(0, CORE_CTRL_OFS, 0);
    chk(prd, 0, "ctrl reset");
    apb(0, WIN_PAGE_OFS, 0);
    chk(prd, 0, "page reset");
    apb(0, 8'h20, 0);
    chk({prd[30:0], perr}, 1, "unmapped");
    $display("test registers done");
    // Writes: lanes, odd word
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      b = r[31];
      ea = 16'h0800 + {7'h00, r[8:0]};
      wd = r[24:9];
      if (b) wd = {wd[7:0], wd[7:0]};
      acc(1, b, ea, wd);
      chk(we1, b ? (ea[0] ? LANE_HI : LANE_LO) : (ea[0] ? LANES_NONE : LANES_ALL), "lanes");
      chk(e1, !b & ea[0], "write trap");
      if (b && ea[0]) sh[ea[8:1]][15:8] = wd[7:0];
      else if (b) sh[ea[8:1]][7:0] = wd[7:0];
      else if (!ea[0]) sh[ea[8:1]] = wd;
    end
    $display("test writes done");
    // Reads: corners, linear, MAC
    for (int i = 0; i < 130; i++)
    begin
      r = $random(seed);
      m = (i % 4 == 3);
      b = !m & r[30];
      {pd, wr} = r[29:28];
      ea = m ? 16'h0800 + {7'h00, r[8:1], 1'b0} : r[15:0] % 16'h0C00;
      if (i < 4) ea = i[1] ? (i[0] ? 16'h8000 : 16'h7FFE) : (i[0] ? 16'h0A00 : 16'h07FE);
      yea = 16'h0800 + {7'h00, r[24:17], 1'b0};
      {mac_i, y_req_i, y_ea_i, post_dec_i, acc_wreg_dst_i} <= {m, m, yea, pd, wr};
      acc(0, b, ea, 0);
      chk(v2, 1, "valid");
      chk(x2, xexp(ea, b, m), "x data");
      if (m) chk(y2, yea >= YRAM_LO ? sh[{1'b1, yea[7:1]}] : 16'h0, "y data");
      chk(ln2, wr ? (b ? LANE_LO : LANES_ALL) : LANES_NONE, "lanes");
      chk(pn, 16'(pd ? ea - (b ? STEP_BYTE : STEP_WORD) : ea + (b ? STEP_BYTE : STEP_WORD)), "ptr");
      chk(e1, !b & ea[0], "read trap");
    end
    {mac_i, y_req_i, post_dec_i, acc_wreg_dst_i} <= 4'h0;
    $display("test reads done");
    // Window: classes, repeat edges, table op
    pg = r[7:0];
    apb(1, WIN_PAGE_OFS, {24'h0, pg});
    apb(1, CORE_CTRL_OFS, 1);
    for (int k = 0; k < 10; k++)
    begin
      r = $random(seed);
      ea = {1'b1, r[14:1], 1'b0};
      rf = (k > 3 && k < 8) ? 4'(1 << (k - 4)) : 4'h0;
      {rep_first_i, rep_last_i, rep_int_exit_i, rep_reentry_i} <= rf;
      {rep_active_i, table_op_i} <= {k > 3 && k < 9, k == 9};
      op_class_i <= dsad_op_e'(k[1:0]);
      acc(0, 0, ea, 0);
      chk(pr1, k != 9, "window read");
      chk(x2, k == 9 ? 16'h0 : {pg[0], ea[14:0]} ^ 16'h3C3C, "window data");
      if (k != 9) chk(pa1, {1'b0, pg, ea[14:0]}, "window addr");
      chk(r1 ? 0 : (r2 ? 1 : 2), (k > 7) ? 0 : (k > 2 ? 2 : 1), "extra");
    end
    $display("test window done");
    tally_and_finish();
  end

  initial
  begin
    #200000;
    n_fail++;
    $display("BAD t=%0t watchdog", $time);
    tally_and_finish();
  end
endmodule : tb
